// >>> inc/sbf_pkg.sv
// shared constants, types and helpers of the shift, bit and flag unit
package sbf_pkg;

    localparam int          DATA_W      = 8;
    localparam int          BIT_W       = 3;
    localparam int          NIBBLE_W    = 4;
    localparam int          IO_ADDR_W   = 3;
    localparam int          IO_COUNT    = 8;
    localparam int          REG_IDX_W   = 5;
    localparam int          APB_ADDR_W  = 12;
    localparam int          APB_DATA_W  = 32;

    // status_register bit positions
    localparam int          STATUS_REGISTER_C      = 0;
    localparam int          STATUS_REGISTER_Z      = 1;
    localparam int          STATUS_REGISTER_N      = 2;
    localparam int          STATUS_REGISTER_V      = 3;
    localparam int          STATUS_REGISTER_S      = 4;
    localparam int          STATUS_REGISTER_H      = 5;
    localparam int          STATUS_REGISTER_T      = 6;
    localparam int          STATUS_REGISTER_I      = 7;

    localparam logic [DATA_W-1:0]     STATUS_REGISTER_RESET  = 8'h00;
    localparam logic [DATA_W-1:0]     IO_RESET    = 8'h00;

    // apb map, byte addresses
    localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET  = 12'h000;
    localparam logic [APB_ADDR_W-1:0] IO_BASE_OFFSET = 12'h010;
    localparam int                    WORD_SHIFT     = 2;

    typedef enum logic [4:0] {
        OP_NOP          = 5'h00,
        OP_POP          = 5'h01,
        OP_SET_IO_BIT   = 5'h02,
        OP_CLR_IO_BIT   = 5'h03,
        OP_SHL_LOGICAL  = 5'h04,
        OP_SHR_LOGICAL  = 5'h05,
        OP_ROT_L_CARRY  = 5'h06,
        OP_ROT_R_CARRY  = 5'h07,
        OP_SHR_ARITH    = 5'h08,
        OP_SWAP_NIBBLE  = 5'h09,
        OP_SET_STAT_BIT = 5'h0A,
        OP_CLR_STAT_BIT = 5'h0B,
        OP_STORE_TO_T   = 5'h0C,
        OP_LOAD_FROM_T  = 5'h0D,
        OP_SET_CARRY    = 5'h0E,
        OP_CLR_CARRY    = 5'h0F,
        OP_SET_NEG      = 5'h10,
        OP_CLR_NEG      = 5'h11,
        OP_SET_ZERO     = 5'h12,
        OP_CLR_ZERO     = 5'h13,
        OP_SET_INTR_EN  = 5'h14,
        OP_CLR_INTR_EN  = 5'h15,
        OP_SET_SIGN     = 5'h16,
        OP_CLR_SIGN     = 5'h17,
        OP_SET_OVF      = 5'h18,
        OP_CLR_OVF      = 5'h19,
        OP_SET_T        = 5'h1A,
        OP_CLR_HALF     = 5'h1B
    } sbf_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_POP  = 2'b10
    } sbf_state_t;

    typedef struct packed {
        sbf_op_t                op;
        logic [REG_IDX_W-1:0]   rd_idx;
        logic [DATA_W-1:0]      rd_val;
        logic [DATA_W-1:0]      src_val;
        logic [BIT_W-1:0]       bit_sel;
        logic [IO_ADDR_W-1:0]   io_addr;
    } sbf_cmd_t;

    typedef struct packed {
        logic                   we;
        logic [REG_IDX_W-1:0]   rd_idx;
        logic [DATA_W-1:0]      data;
    } sbf_wb_t;

    function automatic logic [DATA_W-1:0] put_bit(input logic [DATA_W-1:0] v,
                                                  input logic [BIT_W-1:0]  idx,
                                                  input logic              b);
        logic [DATA_W-1:0] r;
        r      = v;
        r[idx] = b;
        return r;
    endfunction : put_bit

endpackage : sbf_pkg

// >>> rtl/sbf_alu.sv
// combinational shift, rotate, swap and bit/flag datapath
module sbf_alu (
    input  wire logic                     i_en,
    input  wire sbf_pkg::sbf_cmd_t        i_cmd,
    input  wire logic [sbf_pkg::DATA_W-1:0] i_status_register,
    input  wire logic [sbf_pkg::DATA_W-1:0] i_io_val,
    output logic [sbf_pkg::DATA_W-1:0]    o_rd_new,
    output logic                          o_rd_we,
    output logic [sbf_pkg::DATA_W-1:0]    o_status_register_new,
    output logic [sbf_pkg::DATA_W-1:0]    o_io_new,
    output logic                          o_io_we
);
    import sbf_pkg::*;

    logic [DATA_W-1:0] rd;
    logic              cin;
    assign rd  = i_cmd.rd_val;
    assign cin = i_status_register[STATUS_REGISTER_C];

    always_comb begin
        o_rd_new   = rd;
        o_rd_we    = 1'b0;
        o_status_register_new = i_status_register;
        o_io_new   = i_io_val;
        o_io_we    = 1'b0;
        if (i_en) begin
            unique case (i_cmd.op)
                OP_SET_IO_BIT: begin
                    o_io_new = put_bit(i_io_val, i_cmd.bit_sel, 1'b1);
                    o_io_we  = 1'b1;
                end
                OP_CLR_IO_BIT: begin
                    o_io_new = put_bit(i_io_val, i_cmd.bit_sel, 1'b0);
                    o_io_we  = 1'b1;
                end
                OP_SHL_LOGICAL: begin
                    o_rd_new = {rd[DATA_W-2:0], 1'b0};
                    o_rd_we  = 1'b1;
                end
                OP_SHR_LOGICAL: begin
                    o_rd_new = {1'b0, rd[DATA_W-1:1]};
                    o_rd_we  = 1'b1;
                end
                OP_ROT_L_CARRY: begin
                    o_rd_new           = {rd[DATA_W-2:0], cin};
                    o_rd_we            = 1'b1;
                    o_status_register_new[STATUS_REGISTER_C] = rd[DATA_W-1];
                end
                OP_ROT_R_CARRY: begin
                    o_rd_new           = {cin, rd[DATA_W-1:1]};
                    o_rd_we            = 1'b1;
                    o_status_register_new[STATUS_REGISTER_C] = rd[0];
                end
                OP_SHR_ARITH: begin
                    o_rd_new = {rd[DATA_W-1], rd[DATA_W-1:1]};
                    o_rd_we  = 1'b1;
                end
                OP_SWAP_NIBBLE: begin
                    o_rd_new = {rd[NIBBLE_W-1:0], rd[DATA_W-1:NIBBLE_W]};
                    o_rd_we  = 1'b1;
                end
                OP_SET_STAT_BIT: o_status_register_new = put_bit(i_status_register, i_cmd.bit_sel, 1'b1);
                OP_CLR_STAT_BIT: o_status_register_new = put_bit(i_status_register, i_cmd.bit_sel, 1'b0);
                OP_STORE_TO_T:   o_status_register_new[STATUS_REGISTER_T] = i_cmd.src_val[i_cmd.bit_sel];
                OP_LOAD_FROM_T: begin
                    o_rd_new = put_bit(rd, i_cmd.bit_sel, i_status_register[STATUS_REGISTER_T]);
                    o_rd_we  = 1'b1;
                end
                OP_SET_CARRY:   o_status_register_new[STATUS_REGISTER_C] = 1'b1;
                OP_CLR_CARRY:   o_status_register_new[STATUS_REGISTER_C] = 1'b0;
                OP_SET_NEG:     o_status_register_new[STATUS_REGISTER_N] = 1'b1;
                OP_CLR_NEG:     o_status_register_new[STATUS_REGISTER_N] = 1'b0;
                OP_SET_ZERO:    o_status_register_new[STATUS_REGISTER_Z] = 1'b1;
                OP_CLR_ZERO:    o_status_register_new[STATUS_REGISTER_Z] = 1'b0;
                OP_SET_INTR_EN: o_status_register_new[STATUS_REGISTER_I] = 1'b1;
                OP_CLR_INTR_EN: o_status_register_new[STATUS_REGISTER_I] = 1'b0;
                OP_SET_SIGN:    o_status_register_new[STATUS_REGISTER_S] = 1'b1;
                OP_CLR_SIGN:    o_status_register_new[STATUS_REGISTER_S] = 1'b0;
                OP_SET_OVF:     o_status_register_new[STATUS_REGISTER_V] = 1'b1;
                OP_CLR_OVF:     o_status_register_new[STATUS_REGISTER_V] = 1'b0;
                OP_SET_T:       o_status_register_new[STATUS_REGISTER_T] = 1'b1;
                OP_CLR_HALF:    o_status_register_new[STATUS_REGISTER_H] = 1'b0;
                default: begin
                end
            endcase
        end
    end

endmodule : sbf_alu

// >>> rtl/sbf_unit.sv
// shift, bit and flag execution unit with status, i/o bank and apb access
//
// The APB register port and the placing of the registers were chosen for this implementation.
import sbf_pkg::*;

module sbf_unit #(
    parameter int IO_REGS = sbf_pkg::IO_COUNT
) (
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_resetn,
    input  wire logic                              i_cmd_valid,
    input  wire sbf_pkg::sbf_cmd_t                 i_cmd,
    output logic                                   o_cmd_ready,
    input  wire logic [sbf_pkg::DATA_W-1:0]        i_stack_data,
    output logic                                   o_stack_pop,
    output sbf_pkg::sbf_wb_t                       o_wb,
    output logic [sbf_pkg::DATA_W-1:0]             o_status,
    input  wire logic                              i_psel,
    input  wire logic                              i_penable,
    input  wire logic                              i_pwrite,
    input  wire logic [sbf_pkg::APB_ADDR_W-1:0]    i_paddr,
    input  wire logic [sbf_pkg::APB_DATA_W-1:0]    i_pwdata,
    output logic [sbf_pkg::APB_DATA_W-1:0]         o_prdata,
    output logic                                   o_pready,
    output logic                                   o_pslverr
);
    import sbf_pkg::*;

    sbf_state_t                 state_reg;
    sbf_state_t                 state_next;
    logic [DATA_W-1:0]          status_register_reg;
    logic [DATA_W-1:0]          status_register_next;
    logic [DATA_W-1:0]          io_mem [IO_REGS];
    logic                       ready_reg;
    logic                       pop_reg;
    logic [REG_IDX_W-1:0]       pop_idx_reg;
    sbf_wb_t                    wb_reg;
    sbf_wb_t                    wb_next;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic [APB_DATA_W-1:0]      prdata_reg;
    logic [APB_DATA_W-1:0]      prdata_next;

    // command acceptance and datapath
    logic                       accept;
    logic                       accept_pop;
    logic                       accept_alu;
    logic [DATA_W-1:0]          io_rd_val;
    logic [DATA_W-1:0]          alu_rd_new;
    logic                       alu_rd_we;
    logic [DATA_W-1:0]          alu_status_register_new;
    logic [DATA_W-1:0]          alu_io_new;
    logic                       alu_io_we;

    assign accept     = i_cmd_valid && ready_reg;
    assign accept_pop = accept && (i_cmd.op == OP_POP);
    assign accept_alu = accept && (i_cmd.op != OP_POP);
    assign io_rd_val  = io_mem[i_cmd.io_addr];

    sbf_alu u_alu (
        .i_en       (accept_alu),
        .i_cmd      (i_cmd),
        .i_status_register     (status_register_reg),
        .i_io_val   (io_rd_val),
        .o_rd_new   (alu_rd_new),
        .o_rd_we    (alu_rd_we),
        .o_status_register_new (alu_status_register_new),
        .o_io_new   (alu_io_new),
        .o_io_we    (alu_io_we)
    );

    // apb decode, one wait state per access
    logic                       apb_access;
    logic                       apb_done;
    logic                       apb_wr;
    logic                       hit_status;
    logic                       hit_io;
    logic [APB_ADDR_W-1:0]      io_rel;
    logic [IO_ADDR_W-1:0]       io_sel;
    logic                       io_sw_we;

    assign apb_access = i_psel && i_penable;
    assign apb_done   = apb_access && pready_reg;
    assign apb_wr     = apb_done && i_pwrite;
    assign io_rel     = i_paddr - IO_BASE_OFFSET;
    assign io_sel     = IO_ADDR_W'(io_rel >> WORD_SHIFT);
    assign hit_status = (i_paddr == STATUS_OFFSET);
    assign hit_io     = (i_paddr >= IO_BASE_OFFSET) && (io_rel[WORD_SHIFT-1:0] == '0)
                        && ((io_rel >> WORD_SHIFT) < APB_ADDR_W'(IO_REGS));
    assign io_sw_we   = apb_wr && hit_io;

    // next state and result selection
    assign state_next = (state_reg == ST_POP) ? ST_IDLE :
                        (accept_pop ? ST_POP : ST_IDLE);

    // ops that write the status; only these beat a software write in the same cycle
    logic                       alu_status_register_we;
    assign alu_status_register_we = accept_alu && (i_cmd.op inside {OP_ROT_L_CARRY, OP_ROT_R_CARRY, OP_SET_STAT_BIT,
                                                         OP_CLR_STAT_BIT, OP_STORE_TO_T,
                                                         [OP_SET_CARRY:OP_CLR_HALF]});
    assign status_register_next = alu_status_register_we ? alu_status_register_new :
                       (apb_wr && hit_status) ? i_pwdata[DATA_W-1:0] : status_register_reg;

    always_comb begin
        wb_next = '0;
        if (state_reg == ST_POP) begin
            wb_next.we     = 1'b1;
            wb_next.rd_idx = pop_idx_reg;
            wb_next.data   = i_stack_data;
        end else if (alu_rd_we) begin
            wb_next.we     = 1'b1;
            wb_next.rd_idx = i_cmd.rd_idx;
            wb_next.data   = alu_rd_new;
        end
    end

    always_comb begin
        prdata_next = '0;
        if (hit_status) begin
            prdata_next[DATA_W-1:0] = status_register_reg;
        end else if (hit_io) begin
            prdata_next[DATA_W-1:0] = io_mem[io_sel];
        end
    end

    // control registers
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg   <= ST_IDLE;
            ready_reg   <= 1'b1;
            pop_reg     <= 1'b0;
            pop_idx_reg <= '0;
            wb_reg      <= '0;
            status_register_reg    <= STATUS_REGISTER_RESET;
        end else begin
            state_reg   <= state_next;
            ready_reg   <= (state_next == ST_IDLE);
            pop_reg     <= accept_pop;
            pop_idx_reg <= accept_pop ? i_cmd.rd_idx : pop_idx_reg;
            wb_reg      <= wb_next;
            status_register_reg    <= status_register_next;
        end
    end

    // i/o register bank; an operation wins over a software write to the same word
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < IO_REGS; k++) begin
                io_mem[k] <= IO_RESET;
            end
        end else begin
            if (io_sw_we && !(alu_io_we && (io_sel == i_cmd.io_addr))) begin
                io_mem[io_sel] <= i_pwdata[DATA_W-1:0];
            end
            if (alu_io_we) begin
                io_mem[i_cmd.io_addr] <= alu_io_new;
            end
        end
    end

    // apb answer registers
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= apb_access && !pready_reg;
            pslverr_reg <= apb_access && !pready_reg && !(hit_status || hit_io);
            prdata_reg  <= (apb_access && !pready_reg && !i_pwrite) ? prdata_next : '0;
        end
    end

    assign o_cmd_ready = ready_reg;
    assign o_stack_pop = pop_reg;
    assign o_wb        = wb_reg;
    assign o_status    = status_register_reg;
    assign o_prdata    = prdata_reg;
    assign o_pready    = pready_reg;
    assign o_pslverr   = pslverr_reg;

    // checking helpers
    logic is_flag_op;
    assign is_flag_op = i_cmd.op inside {OP_SET_STAT_BIT, OP_CLR_STAT_BIT, OP_STORE_TO_T,
                                         [OP_SET_CARRY:OP_CLR_HALF]};

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    chk_pop_two_cycle: assert property (
        accept_pop |=> o_stack_pop && !o_cmd_ready
                   ##1 (o_wb.we && o_wb.data == $past(i_stack_data) && o_wb.rd_idx == $past(i_cmd.rd_idx, 2)))
        else $error("pop did not complete in two cycles");

    chk_io_bit_set: assert property (
        accept && i_cmd.op == OP_SET_IO_BIT
        |=> io_mem[$past(i_cmd.io_addr)] == put_bit($past(io_rd_val), $past(i_cmd.bit_sel), 1'b1))
        else $error("set_io_bit result wrong");

    chk_io_bit_clear: assert property (
        accept && i_cmd.op == OP_CLR_IO_BIT
        |=> io_mem[$past(i_cmd.io_addr)] == put_bit($past(io_rd_val), $past(i_cmd.bit_sel), 1'b0))
        else $error("clear_io_bit result wrong");

    chk_shift_left: assert property (
        accept && i_cmd.op == OP_SHL_LOGICAL
        |=> o_wb.we && o_wb.data == {$past(i_cmd.rd_val[DATA_W-2:0]), 1'b0})
        else $error("logical left shift wrong");

    chk_shift_right: assert property (
        accept && i_cmd.op == OP_SHR_LOGICAL
        |=> o_wb.we && o_wb.data == {1'b0, $past(i_cmd.rd_val[DATA_W-1:1])})
        else $error("logical right shift wrong");

    chk_rotate_left: assert property (
        accept && i_cmd.op == OP_ROT_L_CARRY
        |=> o_wb.data == {$past(i_cmd.rd_val[DATA_W-2:0]), $past(status_register_reg[STATUS_REGISTER_C])}
            && o_status[STATUS_REGISTER_C] == $past(i_cmd.rd_val[DATA_W-1]))
        else $error("rotate left through carry wrong");

    chk_rotate_right: assert property (
        accept && i_cmd.op == OP_ROT_R_CARRY
        |=> o_wb.data == {$past(status_register_reg[STATUS_REGISTER_C]), $past(i_cmd.rd_val[DATA_W-1:1])}
            && o_status[STATUS_REGISTER_C] == $past(i_cmd.rd_val[0]))
        else $error("rotate right through carry wrong");

    chk_arith_shift: assert property (
        accept && i_cmd.op == OP_SHR_ARITH
        |=> o_wb.data == {$past(i_cmd.rd_val[DATA_W-1]), $past(i_cmd.rd_val[DATA_W-1:1])})
        else $error("arithmetic right shift wrong");

    chk_nibble_swap: assert property (
        accept && i_cmd.op == OP_SWAP_NIBBLE
        |=> o_wb.data == {$past(i_cmd.rd_val[NIBBLE_W-1:0]), $past(i_cmd.rd_val[DATA_W-1:NIBBLE_W])})
        else $error("nibble swap wrong");

    chk_status_bit: assert property (
        accept && i_cmd.op inside {OP_SET_STAT_BIT, OP_CLR_STAT_BIT}
        |=> o_status == put_bit($past(status_register_reg), $past(i_cmd.bit_sel), $past(i_cmd.op) == OP_SET_STAT_BIT))
        else $error("status bit set or clear wrong");

    chk_store_t: assert property (
        accept && i_cmd.op == OP_STORE_TO_T
        |=> o_status[STATUS_REGISTER_T] == $past(i_cmd.src_val[i_cmd.bit_sel]))
        else $error("store_bit_to_t wrong");

    chk_load_t: assert property (
        accept && i_cmd.op == OP_LOAD_FROM_T
        |=> o_wb.we && o_wb.data == put_bit($past(i_cmd.rd_val), $past(i_cmd.bit_sel), $past(status_register_reg[STATUS_REGISTER_T])))
        else $error("load_bit_from_t wrong");

    chk_carry_flag: assert property (
        accept && i_cmd.op inside {OP_SET_CARRY, OP_CLR_CARRY}
        |=> o_status[STATUS_REGISTER_C] == ($past(i_cmd.op) == OP_SET_CARRY))
        else $error("carry flag op wrong");

    chk_neg_zero_flags: assert property (
        accept && i_cmd.op inside {[OP_SET_NEG:OP_CLR_ZERO]}
        |=> ($past(i_cmd.op) == OP_SET_NEG  -> o_status[STATUS_REGISTER_N])
         && ($past(i_cmd.op) == OP_CLR_NEG  -> !o_status[STATUS_REGISTER_N])
         && ($past(i_cmd.op) == OP_SET_ZERO -> o_status[STATUS_REGISTER_Z])
         && ($past(i_cmd.op) == OP_CLR_ZERO -> !o_status[STATUS_REGISTER_Z]))
        else $error("negative or zero flag op wrong");

    chk_intr_sign_ovf: assert property (
        accept && i_cmd.op inside {[OP_SET_INTR_EN:OP_CLR_OVF]}
        |=> ($past(i_cmd.op) == OP_SET_INTR_EN -> o_status[STATUS_REGISTER_I])
         && ($past(i_cmd.op) == OP_CLR_INTR_EN -> !o_status[STATUS_REGISTER_I])
         && ($past(i_cmd.op) == OP_SET_SIGN    -> o_status[STATUS_REGISTER_S])
         && ($past(i_cmd.op) == OP_CLR_SIGN    -> !o_status[STATUS_REGISTER_S])
         && ($past(i_cmd.op) == OP_SET_OVF     -> o_status[STATUS_REGISTER_V])
         && ($past(i_cmd.op) == OP_CLR_OVF     -> !o_status[STATUS_REGISTER_V]))
        else $error("interrupt, sign or overflow flag op wrong");

    chk_t_half_flags: assert property (
        accept && i_cmd.op inside {OP_SET_T, OP_CLR_HALF}
        |=> ($past(i_cmd.op) == OP_SET_T -> o_status[STATUS_REGISTER_T])
         && ($past(i_cmd.op) == OP_CLR_HALF -> !o_status[STATUS_REGISTER_H]) && o_cmd_ready)
        else $error("t set or half-carry clear wrong");

    chk_flag_isolation: assert property (
        accept && is_flag_op && i_cmd.op != OP_SET_STAT_BIT && i_cmd.op != OP_CLR_STAT_BIT
        |=> !o_wb.we && $countones(o_status ^ $past(status_register_reg)) <= 1)
        else $error("flag op disturbed other state");

    chk_pop_refuses: assert property (
        o_stack_pop |-> !o_cmd_ready ##1 o_cmd_ready)
        else $error("pop did not hold off commands for exactly one cycle");

    chk_wb_only_on_op: assert property (
        !accept && state_reg != ST_POP |=> !o_wb.we)
        else $error("write-back without an operation");

    chk_apb_one_wait: assert property (
        i_psel && i_penable && !o_pready |=> o_pready)
        else $error("apb ready not given after one wait state");

    chk_apb_ready_pulse: assert property (
        o_pready |=> !o_pready)
        else $error("apb ready held longer than one cycle");

    chk_apb_unmapped: assert property (
        i_psel && i_penable && !o_pready && !(hit_status || hit_io)
        |=> o_pready && o_pslverr && o_prdata == '0)
        else $error("unmapped apb access not refused");

    chk_apb_status_read: assert property (
        i_psel && i_penable && !o_pready && !i_pwrite && hit_status
        |=> !o_pslverr && o_prdata == APB_DATA_W'($past(status_register_reg)))
        else $error("status read data wrong");

    chk_status_write: assert property (
        apb_wr && hit_status && !alu_status_register_we
        |=> o_status == $past(i_pwdata[DATA_W-1:0]))
        else $error("software status write lost");

    chk_io_write: assert property (
        io_sw_we && !alu_io_we
        |=> io_mem[$past(io_sel)] == $past(i_pwdata[DATA_W-1:0]))
        else $error("software i/o write lost");

    cov_pop: cover property (accept_pop ##2 o_wb.we);
    cov_rotate_carry: cover property (accept && i_cmd.op == OP_ROT_L_CARRY && i_cmd.rd_val[DATA_W-1]);
    cov_io_collision: cover property (io_sw_we && alu_io_we && io_sel == i_cmd.io_addr);
    cov_apb_error: cover property (o_pready && o_pslverr);

endmodule : sbf_unit

// >>> sim/sbf_stack_model.sv
// stack model behind the pop handshake
module sbf_stack_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_pop,
    output logic [7:0]      o_top
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] top_reg;
    // top byte only while popped, inverse otherwise
    assign o_top = i_pop ? top_reg : ~top_reg;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            top_reg <= 8'hA5;
        end else if (i_pop) begin
            top_reg <= top_reg + 8'h3C;
        end
    end
endmodule : sbf_stack_model

// >>> sim/testbench.sv
// self-checking bench for the shift, bit and flag unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbf_pkg::*;
    logic        clk, rstn, valid, ready, psel, pen, pwr, pready, perr, pop, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  stk, status;
    sbf_cmd_t    cmd;
    sbf_wb_t     wb;
    int          n_fail = 0;
    int          checks = 0;
    int          fbit[6] = '{STATUS_REGISTER_C, STATUS_REGISTER_N, STATUS_REGISTER_Z, STATUS_REGISTER_I, STATUS_REGISTER_S, STATUS_REGISTER_V};

    sbf_unit dut (
        .i_clk_sys(clk), .i_resetn(rstn), .i_cmd_valid(valid), .i_cmd(cmd), .o_cmd_ready(ready),
        .i_stack_data(stk), .o_stack_pop(pop), .o_wb(wb), .o_status(status), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr)
    );
    sbf_stack_model stack (.i_clk_sys(clk), .i_resetn(rstn), .i_pop(pop), .o_top(stk));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic op(input sbf_op_t o, input logic [7:0] v, input logic [2:0] b, input logic [7:0] d,
                      input logic [7:0] s);
        logic wr;
        wr = o inside {OP_POP, OP_SHL_LOGICAL, OP_SHR_LOGICAL, OP_ROT_L_CARRY, OP_ROT_R_CARRY, OP_SHR_ARITH,
                       OP_SWAP_NIBBLE, OP_LOAD_FROM_T};
        cmd   <= '{op: o, rd_idx: 5'h07, rd_val: v, src_val: v, bit_sel: b, io_addr: b};
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        if (o == OP_POP) begin
            @(posedge clk);
            chk({31'h0, pop & ~ready}, 32'h1);
        end
        @(posedge clk);
        chk({18'h0, wb}, wr ? {18'h0, 1'b1, 5'h07, d} : 32'h0);
        chk({24'h0, status}, {24'h0, s});
    endtask : op

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        r = prdata;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: no apb ready", $time);
            conclude();
        end else begin
            @(posedge clk);
        end
    endtask : apb

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        rstn   = 1'b0;
        valid  = 1'b0;
        cmd    = '0;
        psel   = 1'b0;
        pen    = 1'b0;
        pwr    = 1'b0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(r, 32'h0);
        $display("test reset done");
        op(OP_SET_CARRY, 8'h96, 3'h0, 8'h00, 8'h01);
        op(OP_SHL_LOGICAL, 8'h96, 3'h0, 8'h2C, 8'h01);
        op(OP_SHR_LOGICAL, 8'h96, 3'h0, 8'h4B, 8'h01);
        op(OP_ROT_L_CARRY, 8'h96, 3'h0, 8'h2D, 8'h01);
        op(OP_ROT_R_CARRY, 8'h96, 3'h0, 8'hCB, 8'h00);
        op(OP_SHR_ARITH, 8'h96, 3'h0, 8'hCB, 8'h00);
        op(OP_SWAP_NIBBLE, 8'h96, 3'h0, 8'h69, 8'h00);
        $display("test shifts done");
        for (int k = 0; k < 6; k++) begin
            op(sbf_op_t'(5'h0E + 5'(2 * k)), 8'h00, 3'h0, 8'h00, 8'(1 << fbit[k]));
            op(sbf_op_t'(5'h0F + 5'(2 * k)), 8'h00, 3'h0, 8'h00, 8'h00);
        end
        op(OP_SET_STAT_BIT, 8'h00, 3'h5, 8'h00, 8'h20);
        op(OP_CLR_HALF, 8'h00, 3'h0, 8'h00, 8'h00);
        op(OP_SET_T, 8'h00, 3'h0, 8'h00, 8'h40);
        op(OP_CLR_STAT_BIT, 8'h00, 3'h6, 8'h00, 8'h00);
        op(OP_STORE_TO_T, 8'h96, 3'h2, 8'h00, 8'h40);
        op(OP_LOAD_FROM_T, 8'h00, 3'h3, 8'h08, 8'h40);
        $display("test flags done");
        op(OP_POP, 8'h00, 3'h0, 8'hA5, 8'h40);
        op(OP_POP, 8'h00, 3'h0, 8'hE1, 8'h40);
        op(OP_SET_IO_BIT, 8'h00, 3'h5, 8'h00, 8'h40);
        apb(1'b0, 12'h024, 32'h0);
        chk(r, 32'h20);
        chk({31'h0, e}, 32'h0);
        apb(1'b1, 12'h024, 32'hFF);
        op(OP_CLR_IO_BIT, 8'h00, 3'h5, 8'h00, 8'h40);
        apb(1'b0, 12'h024, 32'h0);
        chk(r, 32'hDF);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        $display("test pop and io done");
        apb(1'b1, STATUS_OFFSET, 32'hFF);
        op(OP_CLR_OVF, 8'h00, 3'h0, 8'h00, 8'hF7);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(r, 32'hF7);
        chk({31'h0, e}, 32'h0);
        $display("test status write done");
        conclude();
    end
endmodule : testbench
